// *** design/peripheral_event_flags.sv ***
// peripheral event flag register with mask and level interrupt
// assumes event strobes and buffer levels come from logic on aclk
`timescale 1ns/1ps
module peripheral_event_flags
   import event_flags_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [addr_w-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [addr_w-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_buffer_full,
   input wire logic tx_buffer_full,
   input wire logic sync_transfer_done,
   input wire logic capture_event,
   input wire logic compare_match,
   input wire logic byte_timer_match,
   input wire logic wide_timer_overflow,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [flag_w-1:0] flags;
      logic [flag_w-1:0] mask;
      logic [flag_w-1:0] sticky;
      ccp_mode_t mode;
      logic irq;
   } state_t;
   state_t s_q, s_d;
   logic wr_en, wr_ok, rd_ok;
   logic [addr_w-1:0] wr_addr, rd_addr;
   logic [7:0] wr_data;
   logic [31:0] rd_data;
   logic ev_sync, ev_cap, ev_cmp, ev_per, ev_ovf;
   logic [flag_w-1:0] set_v, clr_v, live_v, sticky_set;

   ////////////////////////////////////////////////////////////////////
   // level strobes become one-cycle pulses so a held line sets once
   edge_pulse u_sync (.aclk(aclk), .aresetn(aresetn), .level(sync_transfer_done),
      .pulse(ev_sync));
   edge_pulse u_cap (.aclk(aclk), .aresetn(aresetn), .level(capture_event),
      .pulse(ev_cap));
   edge_pulse u_cmp (.aclk(aclk), .aresetn(aresetn), .level(compare_match),
      .pulse(ev_cmp));
   edge_pulse u_per (.aclk(aclk), .aresetn(aresetn), .level(byte_timer_match),
      .pulse(ev_per));
   edge_pulse u_ovf (.aclk(aclk), .aresetn(aresetn), .level(wide_timer_overflow),
      .pulse(ev_ovf));

   axil_slave u_bus (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_ok(wr_ok),
      .rd_addr(rd_addr), .rd_data(rd_data), .rd_ok(rd_ok)
   );

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      wr_ok = (wr_addr == flags_off) || (wr_addr == mask_off) ||
         (wr_addr == sticky_off) || (wr_addr == mode_off);
      rd_ok = (rd_addr == flags_off) || (rd_addr == mask_off) ||
         (rd_addr == sticky_off) || (rd_addr == mode_off);
      rd_data = 32'h0000_0000;
      case (rd_addr)
         flags_off: rd_data[flag_w-1:0] = s_q.flags;
         mask_off: rd_data[flag_w-1:0] = s_q.mask;
         sticky_off: rd_data[flag_w-1:0] = s_q.sticky;
         mode_off: rd_data[1:0] = s_q.mode;
         default: rd_data = 32'h0000_0000;
      endcase
   end

   always_comb begin
      s_d = s_q;
      set_v = '0;
      clr_v = '0;
      set_v[bit_sync] = ev_sync;
      set_v[bit_ccp] = (s_q.mode == ccp_capture) ? ev_cap :
         (s_q.mode == ccp_compare) ? ev_cmp : 1'b0;
      set_v[bit_per] = ev_per;
      set_v[bit_ovf] = ev_ovf;
      // writing 0 clears a latched flag; writing 1 leaves it as is
      if (wr_en && wr_addr == flags_off) begin
         clr_v = ~wr_data & sw_clear_mask;
      end
      // set wins over a clear in the same cycle
      s_d.flags = (s_q.flags & ~clr_v) | set_v;
      // buffer flags follow the buffer level, never software
      s_d.flags[bit_rx] = rx_buffer_full;
      s_d.flags[bit_tx] = tx_buffer_full;
      s_d.flags[flag_w-1:bit_rx+1] = '0;
      live_v = s_d.flags & ~s_q.flags;
      sticky_set = live_v;
      s_d.sticky = s_q.sticky;
      if (wr_en && wr_addr == sticky_off) begin
         s_d.sticky = s_q.sticky & ~wr_data;
      end
      s_d.sticky = s_d.sticky | sticky_set;
      if (wr_en && wr_addr == mask_off) begin
         s_d.mask = wr_data;
      end
      if (wr_en && wr_addr == mode_off) begin
         case (wr_data[1:0])
            2'h0: s_d.mode = ccp_capture;
            2'h1: s_d.mode = ccp_compare;
            2'h3: s_d.mode = ccp_pwm;
            default: s_d.mode = s_q.mode;
         endcase
      end
      s_d.irq = |(s_d.sticky & s_d.mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q.flags <= flags_rst;
         s_q.mask <= flags_rst;
         s_q.sticky <= flags_rst;
         s_q.mode <= ccp_capture;
         s_q.irq <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign irq = s_q.irq;
endmodule

// *** inc/event_flags_pkg.sv ***
// constants shared by the peripheral event flag block
// assumes a 32-bit axi4-lite bus and one 250 mhz clock
//
// Overview of operation
// - bit 5 reads 1 while the serial receive buffer holds unread data, else 0.
// - bit 4 reads 1 while the serial transmit buffer is full, 0 when empty.
// - bit 3 sets when a sync port transfer completes and holds until software clears it.
// - in capture mode bit 2 sets on a wide timer capture and holds until cleared.
// - in compare mode bit 2 sets on a wide timer compare match and holds until cleared.
// - bit 1 sets when the byte timer equals its period and holds until written to 0.
// - bit 0 sets on wide timer overflow and holds until software clears it.
// - every implemented flag is 0 after power-on reset.
// - a flag sets on its event regardless of any enable bit.
package event_flags_pkg;
   localparam int addr_w = 8;
   localparam logic [7:0] flags_off = 8'h0c;
   localparam logic [7:0] mask_off = 8'h10;
   localparam logic [7:0] sticky_off = 8'h14;
   localparam logic [7:0] mode_off = 8'h18;
   localparam int flag_w = 8;
   localparam int bit_rx = 5;
   localparam int bit_tx = 4;
   localparam int bit_sync = 3;
   localparam int bit_ccp = 2;
   localparam int bit_per = 1;
   localparam int bit_ovf = 0;
   localparam logic [7:0] flags_rst = 8'h00;
   localparam logic [7:0] sw_clear_mask = 8'h0f;
   localparam logic [1:0] resp_okay = 2'b00;
   localparam logic [1:0] resp_slverr = 2'b10;
   typedef enum logic [1:0] {
      ccp_capture = 2'b00,
      ccp_compare = 2'b01,
      ccp_pwm = 2'b11
   } ccp_mode_t;
endpackage

// *** design/edge_pulse.sv ***
// rising-edge detector for one peripheral event strobe
// assumes the input is already in the aclk domain
`timescale 1ns/1ps
module edge_pulse
   import event_flags_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic level,
   output logic pulse
);
   typedef struct packed {
      logic prev;
      logic pulse;
   } state_t;
   state_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.prev = level;
      s_d.pulse = level & ~s_q.prev;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign pulse = s_q.pulse;
endmodule

// *** design/axil_slave.sv ***
// axi4-lite slave front end: takes one write and one read at a time
// assumes the owner answers reads combinationally from rd_addr
`timescale 1ns/1ps
module axil_slave
   import event_flags_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [addr_w-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [addr_w-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_en,
   output logic [addr_w-1:0] wr_addr,
   output logic [7:0] wr_data,
   input wire logic wr_ok,
   output logic [addr_w-1:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);
   typedef struct packed {
      logic aw_have;
      logic w_have;
      logic [addr_w-1:0] awaddr;
      logic [7:0] wdata;
      logic wlane;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_t;
   state_t s_q, s_d;
   logic aw_take, w_take, ar_take, fire;
   always_comb begin
      s_d = s_q;
      aw_take = s_axi_awvalid & ~s_q.aw_have & ~s_q.bvalid;
      w_take = s_axi_wvalid & ~s_q.w_have & ~s_q.bvalid;
      ar_take = s_axi_arvalid & ~s_q.rvalid;
      if (aw_take) begin
         s_d.aw_have = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (w_take) begin
         s_d.w_have = 1'b1;
         s_d.wdata = s_axi_wdata[7:0];
         s_d.wlane = s_axi_wstrb[0];
      end
      fire = s_q.aw_have & s_q.w_have;
      if (fire) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = wr_ok ? resp_okay : resp_slverr;
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (ar_take) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = rd_data;
         s_d.rresp = rd_ok ? resp_okay : resp_slverr;
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign s_axi_awready = ~s_q.aw_have & ~s_q.bvalid;
   assign s_axi_wready = ~s_q.w_have & ~s_q.bvalid;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = ~s_q.rvalid;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   // a write without lane 0 changes nothing but still answers
   assign wr_en = fire & s_q.wlane;
   assign wr_addr = s_q.awaddr;
   assign wr_data = s_q.wdata;
   assign rd_addr = s_axi_araddr;
endmodule

// *** sim/peripheral_event_flags_assertions.sv ***
// checker for the peripheral event flag block
// assumes it is bound to the top module and watches its ports only
`timescale 1ns/1ps
module peripheral_event_flags_assertions
   import event_flags_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [addr_w-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic rx_buffer_full,
   input wire logic tx_buffer_full
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence flag_read;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == flags_off;
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   // buffer flags lag the level by one cycle, then the read adds one more
   a_rx_level: assert property (flag_read |=> s_axi_rdata[bit_rx] == $past(rx_buffer_full, 2))
      else $error("rx flag differs from buffer level");
   a_tx_level: assert property (flag_read |=> s_axi_rdata[bit_tx] == $past(tx_buffer_full, 2))
      else $error("tx flag differs from buffer level");
   a_top_zero: assert property (flag_read |=> s_axi_rdata[7:6] == 2'b00 && s_axi_rresp == resp_okay)
      else $error("reserved flag bits not zero");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   a_wr_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   a_no_accept: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   a_one_resp: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
endmodule
bind peripheral_event_flags peripheral_event_flags_assertions checker_i (.*);

// *** sim/peripheral_event_flags_test.sv ***
// bench for the peripheral event flag block
// assumes the package and the checker are compiled first
`timescale 1ns/1ps
module peripheral_event_flags_test import event_flags_pkg::*; ();
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0, m;
   logic [31:0] wdata = 0, rdata;
   logic [3:0] wstrb = 0;
   logic rx = 0, tx = 0, awready, wready, bvalid, arready, rvalid, irq;
   logic [4:0] evt = 0;
   logic [1:0] bresp, rresp;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int fails = 0, check_count = 0, seed = 32'h292d4d95, n;
   always #2 aclk = ~aclk;
   peripheral_event_flags peripheral_event_flags_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .rx_buffer_full(rx), .tx_buffer_full(tx), .sync_transfer_done(evt[3]),
      .capture_event(evt[2]), .compare_match(evt[4]), .byte_timer_match(evt[1]),
      .wide_timer_overflow(evt[0]), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////
   task check(input logic [33:0] seen, input logic [33:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // bounded wait: a hung handshake ends the run
   task tick;
      @(posedge aclk);
      n++;
      if (n > 40) begin
         fails++;
         tally_and_finish;
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
      bq.push_back(r);
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h0, d};
      wstrb <= 4'hf;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         tick;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [33:0] exp);
      rq.push_back(exp);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         tick;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
   endtask
   task rf(input logic [7:0] f);
      rd(flags_off, {resp_okay, 24'h0, f});
   endtask
   task pulse(input logic [4:0] e);
      @(posedge aclk);
      evt <= e;
      @(posedge aclk);
      evt <= 5'h0;
      repeat (3) @(posedge aclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // responses are judged here, oldest note first
   always @(posedge aclk) begin
      if (rvalid && rready) check({rresp, rdata}, rq.pop_front());
      if (bvalid && bready) check({32'h0, bresp}, {32'h0, bq.pop_front()});
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rf(8'h00);
      rd(sticky_off, {resp_okay, 32'h0});
      for (int i = 0; i < 4; i++) begin
         pulse(5'h01 << i);
         rf(8'h0f >> (3 - i));
      end
      wr(flags_off, 8'h3e, resp_okay);
      rf(8'h0e);
      rx <= 1'b1;
      tx <= 1'b1;
      wr(flags_off, 8'h00, resp_okay);
      rf(8'h30);
      rx <= 1'b0;
      rf(8'h10);
      tx <= 1'b0;
      rf(8'h00);
      wr(mode_off, 8'h01, resp_okay);
      pulse(5'h10);
      rf(8'h04);
      wr(flags_off, 8'h00, resp_okay);
      wr(mode_off, 8'h03, resp_okay);
      // code 2 is not a mode: the block must stay in pwm
      wr(mode_off, 8'h02, resp_okay);
      rd(mode_off, {resp_okay, 32'h3});
      pulse(5'h14);
      rf(8'h00);
      m = 8'($random(seed)) & 8'h3f;
      wr(mask_off, m, resp_okay);
      rd(mask_off, {resp_okay, 24'h0, m});
      repeat (2) @(posedge aclk);
      check({33'h0, irq}, {33'h0, m != 8'h00});
      wr(sticky_off, 8'h3f, resp_okay);
      rd(sticky_off, {resp_okay, 32'h0});
      check({33'h0, irq}, 34'h0);
      wr(mask_off, 8'h01, resp_okay);
      pulse(5'h01);
      check({33'h0, irq}, {33'h0, 1'b1});
      rd(8'h20, {resp_slverr, 32'h0});
      wr(8'h20, 8'hff, resp_slverr);
      tally_and_finish;
   end
endmodule
